// ==== hdl/umr_decoder.sv ====
/*
 * upper memory reclaim decoder: routes each request to dram, the
 * express port, the config space, the south bridge link or invalid, one cycle
 * after it is presented, and remaps dram hidden under the i/o hole.
 * assumes: configuration ports come from logic on clk_in and are
 * stable while requests run; one request per cycle at most.
 */
// Functional notes
// - upstream request with address above 36 bits is an invalid cycle
// - populated dram handled is clamped to 8 GB
// - populated memory top is total dram, not the highest address
// - stolen base is populated top minus stolen size
// - reclaim off: upper usable top is populated top minus stolen
// - reclaim on: upper usable top equals remap window limit
// - remap base is populated top minus stolen, 64 MB aligned
// - low usable top compares only against A[31:20]
// - upper usable top marks direct dram for access, early, trusted flags
// - dram between low usable top and 4 GB remaps from the remap base upward
// - remap window hit translates to dram from low usable top upward
// - window base and limit compare with A[31:20]
// - base low bits zero, limit low bits FFFFFh, 1 MB grain
// - base <= addr <= limit claims for the port, per window
// - port memory enable bit gates both windows
// - upper bits extend prefetch window above 4 GB
// - programmable flat config space base and size
// - stacked mode: channel 0 last row boundary picks channel
// - unclaimed low usable top to 4 GB goes to south bridge link
`timescale 1ns/10ps
`include "umr_defines.svh"

module umr_decoder (
    input  wire logic                     clk_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     req_valid_in,
    input  wire logic                     req_upstream_in,
    input  wire logic [`UMR_REQ_AW-1:0]   req_addr_in,
    input  wire logic [`UMR_MB_W-1:0]     populated_memory_top_in,
    input  wire logic [`UMR_MB_W-1:0]     stolen_size_in,
    input  wire logic                     reclaim_en_in,
    input  wire logic [`UMR_LOW_W-1:0]    low_usable_dram_top_in,
    input  wire logic [`UMR_LOW_W-1:0]    mem_window_base_in,
    input  wire logic [`UMR_LOW_W-1:0]    mem_window_limit_in,
    input  wire logic [`UMR_LOW_W-1:0]    port_prefetch_window_base_in,
    input  wire logic [`UMR_LOW_W-1:0]    port_prefetch_window_limit_in,
    input  wire logic [`UMR_UPPER_W-1:0]  prefetch_base_upper_bits_in,
    input  wire logic [`UMR_UPPER_W-1:0]  prefetch_limit_upper_bits_in,
    input  wire logic [15:0]              port_command_reg_in,
    input  wire logic                     cfg_space_en_in,
    input  wire logic [1:0]               cfg_space_size_in,
    input  wire logic [`UMR_MB_W-1:0]     flat_config_space_base_in,
    input  wire logic                     stacked_mode_in,
    input  wire logic [`UMR_MB_W-1:0]     chan0_last_row_boundary_in,
    output logic                          resp_valid_out,
    output umr_pkg::umr_target_t          resp_target_out,
    output logic [`UMR_PHYS_AW-1:0]       resp_addr_out,
    output logic                          resp_channel_out,
    output logic                          mem_access_out,
    output logic                          early_path_out,
    output logic                          trusted_read_out,
    output logic [`UMR_MB_W-1:0]          stolen_base_out,
    output logic [`UMR_MB_W-1:0]          remap_window_base_out,
    output logic [`UMR_MB_W-1:0]          remap_window_limit_out,
    output logic [`UMR_MB_W-1:0]          upper_usable_dram_top_out,
    output logic                          remap_active_out
);
    import umr_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [`UMR_MB_W-1:0] sat_sub(
        input logic [`UMR_MB_W-1:0] a,
        input logic [`UMR_MB_W-1:0] b
    );
        sat_sub = (a > b) ? a - b : `UMR_RST_MB;
    endfunction : sat_sub

    function automatic logic [`UMR_MB_W-1:0] cfg_mask(input logic [1:0] sel);
        case (sel)
            2'h1:    cfg_mask = `UMR_CFG_MASK_128;
            2'h2:    cfg_mask = `UMR_CFG_MASK_64;
            default: cfg_mask = `UMR_CFG_MASK_256;
        endcase
    endfunction : cfg_mask

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ****************************************
    // boundary arithmetic
    // ****************************************
    logic [`UMR_MB_W-1:0] mem_top_eff;
    logic [`UMR_MB_W-1:0] stolen_base;
    logic [`UMR_MB_W-1:0] remap_base;
    logic [`UMR_MB_W-1:0] low_top;
    logic [`UMR_MB_W-1:0] hole;
    logic [`UMR_MB_W-1:0] remap_limit;
    logic [`UMR_MB_W-1:0] upper_top;
    logic                 remap_active;

    always_comb
    begin
        // dram beyond the supported maximum is never decoded
        mem_top_eff = (populated_memory_top_in > `UMR_MAX_DRAM_MB) ?
                      `UMR_MAX_DRAM_MB : populated_memory_top_in;
        stolen_base = sat_sub(mem_top_eff, stolen_size_in);
        remap_base = stolen_base & `UMR_ALIGN_MASK;
        low_top = {4'h0, low_usable_dram_top_in};
        hole = sat_sub(`UMR_FOUR_GB_MB, low_top);
        remap_limit = remap_base + hole - 16'h0001;
        remap_active = reclaim_en_in && (hole != `UMR_RST_MB);
        upper_top = reclaim_en_in ? remap_limit : stolen_base;
    end

    // ****************************************
    // address decode
    // ****************************************
    logic [`UMR_PHYS_AW-1:0] a36;
    logic [`UMR_MB_W-1:0]    amb;
    logic                    bad_hi;
    logic                    below4g;
    logic                    mem_en;
    logic                    cfg_hit;
    logic                    mem_hit;
    logic                    pf_hit;
    logic                    remap_hit;
    logic                    upper_dram;

    assign a36     = req_addr_in[`UMR_PHYS_AW-1:0];
    assign amb     = a36[`UMR_PHYS_AW-1:`UMR_MB_SHIFT];
    assign bad_hi  = |req_addr_in[`UMR_REQ_AW-1:`UMR_PHYS_AW];
    assign below4g = (amb < `UMR_FOUR_GB_MB);
    assign mem_en  = port_command_reg_in[`UMR_CMD_MEM_EN];

    always_comb
    begin
        cfg_hit = cfg_space_en_in &&
                  ((amb & cfg_mask(cfg_space_size_in)) ==
                   (flat_config_space_base_in & cfg_mask(cfg_space_size_in)));
        // the normal window only reaches below 4 GB
        mem_hit = mem_en && below4g &&
                  (amb[`UMR_LOW_W-1:0] >= mem_window_base_in) &&
                  (amb[`UMR_LOW_W-1:0] <= mem_window_limit_in);
        pf_hit  = mem_en &&
                  (amb >= {prefetch_base_upper_bits_in, port_prefetch_window_base_in}) &&
                  (amb <= {prefetch_limit_upper_bits_in,
                           port_prefetch_window_limit_in});
        remap_hit = remap_active && !below4g &&
                    (amb >= remap_base) && (amb <= remap_limit);
        // an enabled window's limit is inclusive, the plain top is not
        upper_dram = !below4g &&
                     (reclaim_en_in ? (amb <= upper_top) : (amb < upper_top));
    end

    // ****************************************
    // state
    // ****************************************
    umr_state_t st_r;
    umr_state_t st_nxt;

    always_comb
    begin
        logic [`UMR_MB_W-1:0] phys_mb;
        phys_mb = low_top + (amb - remap_base);
        st_nxt = st_r;
        st_nxt.resp_valid   = req_valid_in;
        st_nxt.stolen_base  = stolen_base;
        st_nxt.remap_base   = remap_base;
        st_nxt.remap_limit  = remap_limit;
        st_nxt.upper_top    = upper_top;
        st_nxt.remap_active = remap_active;
        st_nxt.addr         = a36;
        st_nxt.direct       = 1'b0;
        if (req_valid_in)
        begin
            if (req_upstream_in && bad_hi)
                st_nxt.target = UMR_TGT_INVALID;
            else if (cfg_hit)
                st_nxt.target = UMR_TGT_CFG;
            else if (mem_hit || pf_hit)
                st_nxt.target = UMR_TGT_PCIE;
            else if (below4g)
            begin
                if (amb[`UMR_LOW_W-1:0] < low_usable_dram_top_in)
                begin
                    st_nxt.target = UMR_TGT_DRAM;
                    st_nxt.direct = 1'b1;
                end
                else
                    st_nxt.target = UMR_TGT_SBLINK;
            end
            else if (upper_dram)
            begin
                st_nxt.target = UMR_TGT_DRAM;
                st_nxt.direct = 1'b1;
                if (remap_hit)
                    st_nxt.addr = {phys_mb, a36[`UMR_MB_SHIFT-1:0]};
            end
            else
                st_nxt.target = UMR_TGT_SBLINK;
            // stacked: channel 1 starts at channel 0's last row boundary
            st_nxt.channel = stacked_mode_in ?
                (st_nxt.addr[`UMR_PHYS_AW-1:`UMR_MB_SHIFT] >=
                 chan0_last_row_boundary_in) :
                st_nxt.addr[`UMR_IL_CH_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.target <= UMR_TGT_SBLINK;
        end
        else
            st_r <= st_nxt;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign resp_valid_out            = st_r.resp_valid;
    assign resp_target_out           = st_r.target;
    assign resp_addr_out             = st_r.addr;
    assign resp_channel_out          = st_r.channel;
    assign mem_access_out            = st_r.resp_valid && st_r.direct;
    assign early_path_out            = st_r.resp_valid && st_r.direct;
    assign trusted_read_out          = st_r.resp_valid && st_r.direct;
    assign stolen_base_out           = st_r.stolen_base;
    assign remap_window_base_out     = st_r.remap_base;
    assign remap_window_limit_out    = st_r.remap_limit;
    assign upper_usable_dram_top_out = st_r.upper_top;
    assign remap_active_out          = st_r.remap_active;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    invalid_cycle_a: assert property (
        req_valid_in && req_upstream_in && bad_hi |=>
        resp_valid_out && resp_target_out == UMR_TGT_INVALID)
        else $error("oversized upstream address not invalid");

    dram_cap_a: assert property (
        !reclaim_en_in |=> upper_usable_dram_top_out <= `UMR_MAX_DRAM_MB)
        else $error("upper top beyond 8 GB");

    // boundary outputs lag the internal reset release by one edge
    stolen_base_a: assert property (
        rst_n && populated_memory_top_in <= `UMR_MAX_DRAM_MB &&
        stolen_size_in <= populated_memory_top_in |=>
        stolen_base_out == $past(populated_memory_top_in) - $past(stolen_size_in))
        else $error("stolen base wrong");

    top_noreclaim_a: assert property (
        !reclaim_en_in |=> upper_usable_dram_top_out == stolen_base_out)
        else $error("upper top not stolen base");

    top_reclaim_a: assert property (
        reclaim_en_in |=> upper_usable_dram_top_out == remap_window_limit_out)
        else $error("upper top not remap limit");

    remap_align_a: assert property (
        ##1 remap_window_base_out[5:0] == 6'h00 &&
        stolen_base_out - remap_window_base_out < 16'h0040)
        else $error("remap base misaligned");

    low_dram_a: assert property (
        req_valid_in && !(req_upstream_in && bad_hi) && !cfg_hit && !mem_en && below4g &&
        req_addr_in[31:20] < low_usable_dram_top_in |=>
        resp_target_out == UMR_TGT_DRAM && resp_addr_out == $past(a36))
        else $error("low dram not routed");

    sb_default_a: assert property (
        req_valid_in && !(req_upstream_in && bad_hi) && !cfg_hit && !mem_en && below4g &&
        req_addr_in[31:20] >= low_usable_dram_top_in |=>
        resp_target_out == UMR_TGT_SBLINK)
        else $error("hole not sent to south bridge link");

    port_off_a: assert property (
        req_valid_in && !mem_en |=> resp_target_out != UMR_TGT_PCIE)
        else $error("port claimed while disabled");

    port_claim_a: assert property (
        req_valid_in && !(req_upstream_in && bad_hi) && !cfg_hit && mem_en &&
        below4g && req_addr_in[31:20] == mem_window_base_in &&
        mem_window_base_in <= mem_window_limit_in |=>
        resp_target_out == UMR_TGT_PCIE)
        else $error("window base not claimed");

    remap_xlate_a: assert property (
        req_valid_in && !cfg_hit && !mem_en && !bad_hi &&
        remap_hit && amb == remap_base |=>
        resp_addr_out[35:20] == {4'h0, $past(low_usable_dram_top_in)} &&
        mem_access_out)
        else $error("remap base not translated");

    stacked_ch_a: assert property (
        req_valid_in && stacked_mode_in && !mem_en && !cfg_hit &&
        !(req_upstream_in && bad_hi) &&
        below4g && req_addr_in[31:20] < low_usable_dram_top_in |=>
        resp_channel_out == (resp_addr_out[35:20] >= $past(chan0_last_row_boundary_in)))
        else $error("stacked channel wrong");

    upper_dram_a: assert property (
        req_valid_in && !(req_upstream_in && bad_hi) && !cfg_hit && !mem_en &&
        amb == `UMR_FOUR_GB_MB && upper_top > `UMR_FOUR_GB_MB |=>
        resp_target_out == UMR_TGT_DRAM && mem_access_out && early_path_out &&
        trusted_read_out)
        else $error("dram above 4 GB not marked direct");

    upper_hole_a: assert property (
        req_valid_in && !(req_upstream_in && bad_hi) && !cfg_hit && !mem_en &&
        !below4g && amb > upper_top |=>
        resp_target_out == UMR_TGT_SBLINK && !mem_access_out)
        else $error("address above upper top not sent to south bridge link");

    cfg_claim_a: assert property (
        req_valid_in && !(req_upstream_in && bad_hi) && cfg_space_en_in &&
        amb == flat_config_space_base_in |=>
        resp_target_out == UMR_TGT_CFG)
        else $error("config space base not claimed");

    pf_high_a: assert property (
        req_valid_in && !(req_upstream_in && bad_hi) && !cfg_hit && mem_en &&
        amb == {prefetch_base_upper_bits_in, port_prefetch_window_base_in} &&
        prefetch_base_upper_bits_in != 4'h0 &&
        {prefetch_base_upper_bits_in, port_prefetch_window_base_in} <=
        {prefetch_limit_upper_bits_in, port_prefetch_window_limit_in} |=>
        resp_target_out == UMR_TGT_PCIE)
        else $error("prefetch window above 4 GB not claimed");

    invalid_c: cover property (resp_valid_out && resp_target_out == UMR_TGT_INVALID);
    port_c:    cover property (resp_valid_out && resp_target_out == UMR_TGT_PCIE);
    remap_c:   cover property (req_valid_in && remap_hit ##1 mem_access_out);
    sblink_c:  cover property (resp_valid_out && resp_target_out == UMR_TGT_SBLINK);
    cfg_c:     cover property (resp_valid_out && resp_target_out == UMR_TGT_CFG);

endmodule : umr_decoder

// ==== inc/umr_defines.svh ====
/*
 * constants of the upper memory reclaim decoder
 * assumes: included by umr_pkg, the decoder, the bench and the requester
 */
`ifndef UMR_DEFINES_SVH
`define UMR_DEFINES_SVH

// ****************************************
// widths
// ****************************************
`define UMR_REQ_AW       40
`define UMR_PHYS_AW      36
`define UMR_MB_W         16
`define UMR_LOW_W        12
`define UMR_UPPER_W      4
`define UMR_MB_SHIFT     20

// ****************************************
// boundaries, in 1 MB units
// ****************************************
`define UMR_FOUR_GB_MB   16'h1000
`define UMR_MAX_DRAM_MB  16'h2000
`define UMR_ALIGN_MASK   16'hFFC0

// ****************************************
// configuration space size masks
// ****************************************
`define UMR_CFG_MASK_256 16'hFF00
`define UMR_CFG_MASK_128 16'hFF80
`define UMR_CFG_MASK_64  16'hFFC0

// ****************************************
// field positions and reset values
// ****************************************
`define UMR_CMD_MEM_EN   1
`define UMR_IL_CH_BIT    6
`define UMR_RST_MB       16'h0000

`endif

// ==== inc/umr_pkg.sv ====
/*
 * types of the upper memory reclaim decoder
 * assumes: umr_defines.svh is on the include path
 */
`include "umr_defines.svh"

package umr_pkg;

    typedef enum logic [2:0] {
        UMR_TGT_DRAM,
        UMR_TGT_PCIE,
        UMR_TGT_SBLINK,
        UMR_TGT_CFG,
        UMR_TGT_INVALID
    } umr_target_t;

    typedef struct packed {
        logic                     resp_valid;
        umr_target_t              target;
        logic [`UMR_PHYS_AW-1:0]  addr;
        logic                     channel;
        logic                     direct;
        logic [`UMR_MB_W-1:0]     stolen_base;
        logic [`UMR_MB_W-1:0]     remap_base;
        logic [`UMR_MB_W-1:0]     remap_limit;
        logic [`UMR_MB_W-1:0]     upper_top;
        logic                     remap_active;
    } umr_state_t;

endpackage : umr_pkg

// ==== verif/umr_decoder_test.sv ====
/*
 * self-checking bench of the reclaim decoder: four configurations, edge
 * addresses and random traffic, answers checked against a queue of notes
 * assumes: umr_pkg compiled first, umr_requester as the requester
 */
`timescale 1ns/10ps
`include "umr_defines.svh"

module umr_decoder_test;
    import umr_pkg::*;
`define UMR_CHK(got, exp) \
    begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); end end

    typedef struct packed {
        umr_target_t target;
        logic [35:0] addr;
        logic        channel;
    } umr_exp_t;

    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        req_valid, req_up, reclaim, cfg_en, stacked, started = 1'b0;
    logic [39:0] req_addr;
    logic [15:0] top, stolen, cmd, cfg_base, chan0, e_sb, e_rb, e_rl, e_ut;
    logic [11:0] low, mbase, mlimit, pbase, plimit;
    logic [3:0]  pbu, plu;
    logic [1:0]  cfg_size;
    logic        resp_valid, resp_channel, mem_access, early_path, trusted_read, ractive;
    umr_target_t resp_target;
    logic [35:0] resp_addr;
    logic [15:0] stolen_base, rbase_o, rlimit_o, utop_o;
    umr_exp_t    exp_q[$];
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic [31:0] rng = 32'h929f;

    always #5 clk_in = ~clk_in;

    umr_requester req_u (.clk_in(clk_in), .req_valid_out(req_valid),
        .req_upstream_out(req_up), .req_addr_out(req_addr));

    umr_decoder dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid),
        .req_upstream_in(req_up), .req_addr_in(req_addr), .populated_memory_top_in(top),
        .stolen_size_in(stolen), .reclaim_en_in(reclaim), .low_usable_dram_top_in(low),
        .mem_window_base_in(mbase), .mem_window_limit_in(mlimit),
        .port_prefetch_window_base_in(pbase), .port_prefetch_window_limit_in(plimit),
        .prefetch_base_upper_bits_in(pbu), .prefetch_limit_upper_bits_in(plu),
        .port_command_reg_in(cmd), .cfg_space_en_in(cfg_en), .cfg_space_size_in(cfg_size),
        .flat_config_space_base_in(cfg_base), .stacked_mode_in(stacked),
        .chan0_last_row_boundary_in(chan0), .resp_valid_out(resp_valid),
        .resp_target_out(resp_target), .resp_addr_out(resp_addr),
        .resp_channel_out(resp_channel), .mem_access_out(mem_access),
        .early_path_out(early_path), .trusted_read_out(trusted_read),
        .stolen_base_out(stolen_base), .remap_window_base_out(rbase_o),
        .remap_window_limit_out(rlimit_o), .upper_usable_dram_top_out(utop_o),
        .remap_active_out(ractive));

    // ****************************************
    // reference model
    // ****************************************
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    function automatic void calc_bounds();
        logic [15:0] t;
        t    = (top > `UMR_MAX_DRAM_MB) ? `UMR_MAX_DRAM_MB : top;
        e_sb = (t >= stolen) ? t - stolen : 16'h0000;
        e_rb = e_sb & `UMR_ALIGN_MASK;
        e_rl = e_rb + (`UMR_FOUR_GB_MB - {4'h0, low}) - 16'h0001;
        e_ut = reclaim ? e_rl : e_sb;
    endfunction : calc_bounds

    function automatic umr_exp_t exp_route(input logic [39:0] a, input logic up);
        umr_exp_t    e;
        logic [15:0] mb, msk;
        logic        pcie;
        mb  = a[35:20];
        msk = (cfg_size == 2'h1) ? `UMR_CFG_MASK_128 :
              (cfg_size == 2'h2) ? `UMR_CFG_MASK_64 : `UMR_CFG_MASK_256;
        pcie = (mb < `UMR_FOUR_GB_MB && mb[11:0] >= mbase && mb[11:0] <= mlimit)
            || (mb >= {pbu, pbase} && mb <= {plu, plimit});
        e.addr   = a[35:0];
        e.target = UMR_TGT_SBLINK;
        if (up && a[39:36] != 4'h0)
            e.target = UMR_TGT_INVALID;
        else if (cfg_en && (mb & msk) == (cfg_base & msk))
            e.target = UMR_TGT_CFG;
        else if (cmd[`UMR_CMD_MEM_EN] && pcie)
            e.target = UMR_TGT_PCIE;
        else if (mb < `UMR_FOUR_GB_MB)
            e.target = (mb[11:0] < low) ? UMR_TGT_DRAM : UMR_TGT_SBLINK;
        else if (reclaim ? mb <= e_ut : mb < e_ut)
        begin
            e.target = UMR_TGT_DRAM;
            if (reclaim && mb >= e_rb && mb <= e_rl)
                e.addr[35:20] = {4'h0, low} + (mb - e_rb);
        end
        e.channel = stacked ? (e.addr[35:20] >= chan0) : e.addr[`UMR_IL_CH_BIT];
        return e;
    endfunction : exp_route

    // ****************************************
    // drivers and checks
    // ****************************************
    task automatic set_cfg(input int p);
        reclaim  = (p != 2);
        low      = (p == 3) ? 12'h800 : (p == 2) ? 12'hC10 : 12'hC00;
        top      = (p == 3) ? 16'h1800 : (p == 2) ? 16'h2400 : 16'h2000;
        stolen   = (p == 3) ? 16'h0000 : (p == 2) ? 16'h0030 : 16'h0010;
        cmd      = 16'(xs());
        cmd[`UMR_CMD_MEM_EN] = (p != 1);
        cfg_size = 2'h2 - p[1:0];
        stacked  = p[0];
        // windows kept clear of dram and of each other
        {mbase, mlimit, pbase, plimit} = {12'hD00, 12'hD0F, 12'h400, 12'h4FF};
        {pbu, plu, cfg_en, cfg_base, chan0} = {4'h2, 4'h2, 1'b1, 16'h3000, 16'h1000};
        calc_bounds();
    endtask : set_cfg

    task automatic issue(input logic [39:0] a, input logic up);
        exp_q.push_back(exp_route(a, up));
        req_u.send(a, up);
    endtask : issue

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    always @(negedge clk_in)
    begin
        umr_exp_t e;
        logic     d;
        d = 1'b0;
        if (started && resp_valid === 1'b1)
        begin
            `UMR_CHK(exp_q.size() > 0, 1'b1)
            e = exp_q.pop_front();
            d = (e.target == UMR_TGT_DRAM);
            `UMR_CHK(resp_target, e.target)
            `UMR_CHK(resp_addr, e.addr)
            if (d)
                `UMR_CHK(resp_channel, e.channel)
        end
        if (started)
            `UMR_CHK({mem_access, early_path, trusted_read}, {3{d}})
    end

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            finish_test();
        end
    end

    initial
    begin
        logic [15:0] mbl [19];
        logic [31:0] r;
        set_cfg(0);
        repeat (3) @(posedge clk_in);
        #1;
        `UMR_CHK({resp_valid, resp_target, mem_access}, {1'b0, UMR_TGT_SBLINK, 1'b0})
        started  = 1'b1;
        rst_n_in = 1'b1;
        repeat (4) req_u.idle();
        for (int p = 0; p < 4; p++)
        begin
            set_cfg(p);
            repeat (3) req_u.idle();
            `UMR_CHK(stolen_base, e_sb)
            `UMR_CHK(rbase_o, e_rb)
            `UMR_CHK(utop_o, e_ut)
            `UMR_CHK(ractive, reclaim)
            `UMR_CHK(rlimit_o, e_rl)
            mbl = '{{4'h0, low} - 16'h1, {4'h0, low}, 16'h0D00, 16'h0D0F, 16'h0D10,
                    16'h1000, e_rb - 16'h1, e_rb, e_rl, e_rl + 16'h1, e_ut, e_ut + 16'h1,
                    16'h2400, 16'h24FF, 16'h2500, 16'h3000, 16'h303F, 16'h3040, 16'h30FF};
            foreach (mbl[i])
            begin
                r = xs();
                issue({4'h0, mbl[i], r[19:0]}, i[0]);
            end
            issue({4'h1, xs(), 4'h0}, 1'b1);
            issue({4'h8, 16'h0100, 20'h00000}, 1'b0);
            for (int k = 0; k < 64; k++)
            begin
                r = xs();
                issue({(r[2:0] == 3'h0) ? r[7:4] : 4'h0, 2'b00, r[9:8], xs()}, r[12]);
            end
            req_u.idle();
        end
        repeat (3) req_u.idle();
        `UMR_CHK(exp_q.size(), 0)
        finish_test();
    end
endmodule : umr_decoder_test

// ==== verif/umr_requester.sv ====
/*
 * requester model: a processor bus or upstream port issuing decode requests
 * assumes: tasks are entered just after a rising edge of clk_in
 */
`timescale 1ns/10ps
`include "umr_defines.svh"

module umr_requester (
    input  wire logic                   clk_in,
    output logic                        req_valid_out,
    output logic                        req_upstream_out,
    output logic [`UMR_REQ_AW-1:0]      req_addr_out
);
    initial
    begin
        req_valid_out    = 1'b0;
        req_upstream_out = 1'b0;
        req_addr_out     = '0;
    end

    // request held over the taking edge, then the caller may go again
    task automatic send(input logic [`UMR_REQ_AW-1:0] addr, input logic upstream);
        req_valid_out    = 1'b1;
        req_upstream_out = upstream;
        req_addr_out     = addr;
        @(posedge clk_in);
        #1;
    endtask : send

    // released lines flip so a stale address never passes for a request
    task automatic idle();
        req_valid_out    = 1'b0;
        req_upstream_out = ~req_upstream_out;
        req_addr_out     = ~req_addr_out;
        @(posedge clk_in);
        #1;
    endtask : idle
endmodule : umr_requester
